// *** pkg/hrap_consts.vh ***
`ifndef HRAP_CONSTS_VH
`define HRAP_CONSTS_VH
`define HRAP_ADDR_W 14
`define HRAP_DATA_W 8
`define HRAP_POL_BIT 7
`define HRAP_PHA_BIT 6
`define HRAP_ORD_BIT 5
`define HRAP_SCK_BIT 2
`define HRAP_MOSI_BIT 1
`define HRAP_MISO_BIT 0
`define HRAP_CTRL_RW_BIT 0
`define HRAP_CTRL_B_BIT 15
`define HRAP_CMD_BITS 16
`define HRAP_FRAME_BITS 24
`endif

// *** src/hrap_port.v ***
`timescale 1ns/10ps
`default_nettype none
`include "hrap_consts.vh"
module hrap_port #(
  parameter ADDR_W = `HRAP_ADDR_W,
  parameter DATA_W = `HRAP_DATA_W
) (
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // host pins
  input wire chip_select_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire serial_select,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out,
  output reg [DATA_W-1:0] data_oe,
  // register file side
  output reg [ADDR_W-1:0] reg_addr,
  output reg [DATA_W-1:0] reg_wdata,
  output reg reg_write,
  output reg reg_read,
  input wire [DATA_W-1:0] reg_rdata
);
  reg rst_a_r;
  reg rst_b_r;
  // design-wide reset, released two ref_clk edges after the pin
  wire rst_n = rst_b_r;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end

  // three-stage sync for cs, rd, wr, sel and all data pins
  // a change counts only once the second and third stages agree
  localparam SW = DATA_W + 4;
  // reset values match the idle pin levels, so no false edge after reset
  localparam [SW-1:0] SYNC_INIT = {1'b0, 3'b111, {DATA_W{1'b0}}};
  wire [SW-1:0] raw = {serial_select, write_strobe_n, read_strobe_n, chip_select_n, data_in};
  reg [SW-1:0] s1_r;
  reg [SW-1:0] s2_r;
  reg [SW-1:0] s3_r;
  reg [SW-1:0] st_r;
  genvar g;
  generate
    for (g = 0; g < SW; g = g + 1) begin : g_sync
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[g] <= SYNC_INIT[g];
          s2_r[g] <= SYNC_INIT[g];
          s3_r[g] <= SYNC_INIT[g];
          st_r[g] <= SYNC_INIT[g];
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            st_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  wire [DATA_W-1:0] d_s = st_r[DATA_W-1:0];
  wire cs_n = st_r[DATA_W];
  wire rd_n = st_r[DATA_W+1];
  wire wr_n = st_r[DATA_W+2];
  wire spi_mode = st_r[DATA_W+3];

  // previous values for edge detection
  reg wr_n_d_r;
  reg rd_n_d_r;
  reg cs_n_d_r;
  reg sck_d_r;
  reg rw_r;
  reg miso_r;
  reg ord_r;
  reg pol_r;
  reg pha_r;
  wire sck = d_s[`HRAP_SCK_BIT];
  wire mosi = d_s[`HRAP_MOSI_BIT];
  wire cpol = d_s[`HRAP_POL_BIT];
  wire cpha = d_s[`HRAP_PHA_BIT];
  wire msb_first = d_s[`HRAP_ORD_BIT];

  // edges of the host clock, seen after the synchroniser
  wire sck_rise = sck & ~sck_d_r;
  wire sck_fall = ~sck & sck_d_r;
  // latched straps, so one frame keeps one mode
  // sample edge: leading edge when pha_r=0, trailing when pha_r=1
  wire lead = pol_r ? sck_fall : sck_rise;
  wire trail = pol_r ? sck_rise : sck_fall;
  wire smp = pha_r ? trail : lead;
  wire shf = pha_r ? lead : trail;

  // serial state
  reg [4:0] cnt_r;
  reg [`HRAP_CMD_BITS-1:0] cmd_r;
  reg [DATA_W-1:0] sh_r;
  // last bit of the control word and of the whole frame
  wire cmd_last = (cnt_r == `HRAP_CMD_BITS - 1);
  wire frame_last = (cnt_r == `HRAP_FRAME_BITS - 1);
  integer i;
  reg [ADDR_W-1:0] ad_fix;
  reg [DATA_W-1:0] wd_fix;
  reg [DATA_W-1:0] rd_fix;

  always @* begin
    ad_fix = {ADDR_W{1'b0}};
    wd_fix = {DATA_W{1'b0}};
    rd_fix = {DATA_W{1'b0}};
    // address field bits 14:1, flags at 0 and 15 stay put
    for (i = 0; i < ADDR_W; i = i + 1)
      ad_fix[i] = ord_r ? cmd_r[ADDR_W - i] : cmd_r[i + 1];
    // shifter sends its top bit first, so least significant first reverses
    for (i = 0; i < DATA_W; i = i + 1) begin
      wd_fix[i] = ord_r ? sh_r[i] : sh_r[DATA_W-1-i];
      rd_fix[i] = ord_r ? reg_rdata[i] : reg_rdata[DATA_W-1-i];
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_n_d_r <= 1'b1;
      rd_n_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
      sck_d_r <= 1'b0;
      cnt_r <= 5'h00;
      cmd_r <= 16'h0000;
      sh_r <= {DATA_W{1'b0}};
      rw_r <= 1'b0;
      miso_r <= 1'b0;
      ord_r <= 1'b0;
      pol_r <= 1'b0;
      pha_r <= 1'b0;
      reg_addr <= {ADDR_W{1'b0}};
      reg_wdata <= {DATA_W{1'b0}};
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      data_out <= {DATA_W{1'b0}};
      data_oe <= {DATA_W{1'b0}};
    end else begin
      wr_n_d_r <= wr_n;
      rd_n_d_r <= rd_n;
      cs_n_d_r <= cs_n;
      sck_d_r <= sck;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      // parallel path: levels of cs and rd, rising edge of wr
      if (!spi_mode) begin
        if (!cs_n && !rd_n) begin
          reg_addr <= addr;
          data_out <= reg_rdata;
          data_oe <= {DATA_W{1'b1}};
          if (rd_n_d_r)
            reg_read <= 1'b1;
        end else begin
          data_oe <= {DATA_W{1'b0}};
        end
        // write lands on the rising edge of the strobe
        if (!cs_n && wr_n && !wr_n_d_r) begin
          reg_addr <= addr;
          reg_wdata <= d_s;
          reg_write <= 1'b1;
        end
      end else if (cs_n) begin
        // a cut frame ends here: count cleared, pin released
        cnt_r <= 5'h00;
        data_oe <= {DATA_W{1'b0}};
        // straps latched while idle, held through the frame
        ord_r <= msb_first;
        pol_r <= cpol;
        pha_r <= cpha;
      end else begin
        // serial frame: 16 control bits then 8 data bits
        data_oe <= {{DATA_W-1{1'b0}}, 1'b1};
        data_out <= {{DATA_W-1{1'b0}}, miso_r};
        if (smp && cnt_r < `HRAP_FRAME_BITS) begin
          cnt_r <= cnt_r + 5'h01;
          // a read frame shifts only on the other edge
          if (cnt_r < `HRAP_CMD_BITS)
            cmd_r[cnt_r[3:0]] <= mosi;
          else if (!rw_r)
            sh_r <= {sh_r[DATA_W-2:0], mosi};
          if (cmd_last) begin
            rw_r <= cmd_r[`HRAP_CTRL_RW_BIT];
            if (cmd_r[`HRAP_CTRL_RW_BIT]) begin
              reg_addr <= ad_fix;
              reg_read <= 1'b1;
            end
          end
          if (frame_last && !rw_r) begin
            reg_addr <= ad_fix;
            reg_write <= 1'b1;
          end
        end

        // reg_rdata follows reg_addr in the pulse cycle; load exactly once
        if (reg_read)
          sh_r <= rd_fix;
        if (shf && cnt_r >= `HRAP_CMD_BITS && rw_r) begin
          miso_r <= sh_r[DATA_W-1];
          sh_r <= {sh_r[DATA_W-2:0], 1'b0};
        end
        // write data reordered from the full shift register
        if (reg_write)
          reg_wdata <= wd_fix;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/hrap_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module hrap_props (
  input wire logic ref_clk, resetn, chip_select_n, read_strobe_n, write_strobe_n,
  input wire logic serial_select, reg_write, reg_read,
  input wire logic [7:0] data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_idle; chip_select_n [*8] |-> data_oe == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("bus driven");
  property p_rd; (!chip_select_n && !read_strobe_n && !serial_select) [*8] |-> data_oe == 8'hff;
  endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_nord; (read_strobe_n && !serial_select) [*8] |-> data_oe == 8'h00; endproperty
  a_nord: assert property (p_nord) else $error("driven w/o read");
  property p_nowr; (chip_select_n && !serial_select) [*8] |-> !reg_write && !reg_read; endproperty
  a_nowr: assert property (p_nowr) else $error("strobe w/o select");
  property p_wr; $rose(write_strobe_n) && !chip_select_n && !serial_select |-> ##[2:8] reg_write;
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_wpulse; reg_write |=> !reg_write; endproperty
  a_wpulse: assert property (p_wpulse) else $error("write pulse long");
  property p_rpulse; reg_read |=> !reg_read; endproperty
  a_rpulse: assert property (p_rpulse) else $error("read pulse long");
  property p_miso; serial_select |-> data_oe[7:1] == 7'h00; endproperty
  a_miso: assert property (p_miso) else $error("serial drives pins");
  property p_sdrv; (!chip_select_n && serial_select) [*8] |-> data_oe == 8'h01; endproperty
  a_sdrv: assert property (p_sdrv) else $error("serial output not driven");
endmodule
bind hrap_port hrap_props u_props (.ref_clk(ref_clk), .resetn(resetn),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .serial_select(serial_select),
  .reg_write(reg_write), .reg_read(reg_read), .data_oe(data_oe));
`default_nettype wire

// *** verification/hrap_regfile.sv ***
`timescale 1ns/10ps
`default_nettype none
module hrap_regfile (
  input wire logic ref_clk,
  input wire logic [13:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  output logic [7:0] reg_rdata
);
  logic [7:0] mem [0:15];
  logic wr_d;
  initial for (int i = 0; i < 16; i++) mem[i] = 8'h50 + 8'(i);
  // data lands one cycle after the pulse
  always @(posedge ref_clk) begin
    wr_d <= reg_write;
    if (wr_d) mem[reg_addr[3:0]] <= reg_wdata;
  end
  assign reg_rdata = mem[reg_addr[3:0]];
endmodule
`default_nettype wire

// *** verification/hrap_port_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module hrap_port_test;
  logic ref_clk = 0, resetn = 0, chip_select_n = 1, read_strobe_n = 1;
  logic write_strobe_n = 1, serial_select = 0;
  logic [13:0] addr = 0;
  logic [7:0] host_d = 0;
  logic [7:0] sgot;
  wire [7:0] data_in, data_out, data_oe, reg_wdata, reg_rdata;
  wire [13:0] reg_addr;
  wire reg_write, reg_read;
  int n_errors = 0, total_checks = 0;
  assign data_in = (data_out & data_oe) | (host_d & ~data_oe);
  hrap_port uut (.ref_clk(ref_clk), .resetn(resetn), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .serial_select(serial_select), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  hrap_regfile rf (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata));
  initial forever #12.5 ref_clk = ~ref_clk;
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check_addr(input string what, input logic [13:0] exp, input logic [13:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task par_wr(input logic [13:0] a, input logic [7:0] d, input logic cs);
    addr = a;
    host_d = d;
    chip_select_n = cs;
    cyc(8);
    write_strobe_n = 0;
    cyc(8);
    check("write idle", 8'h00, data_oe);
    write_strobe_n = 1;
    cyc(8);
    if (!cs) check_addr("write addr", a, reg_addr);
    chip_select_n = 1;
    cyc(8);
  endtask
  task par_rd(input logic [13:0] a, input logic [7:0] exp);
    addr = a;
    chip_select_n = 0;
    read_strobe_n = 0;
    cyc(10);
    check("read data", exp, data_in);
    check("read drive", 8'hff, data_oe);
    read_strobe_n = 1;
    chip_select_n = 1;
    cyc(10);
    check("released", 8'h00, data_oe);
  endtask
  task t_parallel;
    par_wr(14'h0003, 8'ha5, 0);
    par_wr(14'h0004, 8'h3c, 1);
    par_rd(14'h0003, 8'ha5);
    par_rd(14'h0004, 8'h54);
  endtask
  task spi_xfer(input logic pol, input logic pha, input logic ord, input logic rd,
    input logic [13:0] a, input logic [7:0] wd, output logic [7:0] got);
    logic [23:0] w;
    w = 24'h000000;
    w[0] = rd;
    for (int i = 0; i < 14; i++) w[i+1] = ord ? a[13-i] : a[i];
    for (int i = 0; i < 8; i++) w[16+i] = ord ? wd[7-i] : wd[i];
    got = 8'h00;
    serial_select = 1;
    host_d = {pol, pha, ord, 2'b00, pol, 2'b00};
    cyc(8);
    chip_select_n = 0;
    for (int i = 0; i < 24; i++) begin
      if (pha) host_d[2] = !pol;
      host_d[1] = w[i];
      cyc(4);
      host_d[2] = pha ? pol : !pol;
      cyc(3);
      if (i >= 16) got[ord ? 23 - i : i - 16] = data_in[0];
      if (i == 20) check("serial drive", 8'h01, data_oe);
      cyc(1);
      if (!pha) host_d[2] = pol;
    end
    cyc(4);
    chip_select_n = 1;
    cyc(8);
    check("serial idle", 8'h00, data_oe);
  endtask
  task t_serial;
    spi_xfer(0, 0, 0, 1, 14'h0005, 8'h00, sgot);
    check("serial read lsb", 8'h55, sgot);
    spi_xfer(0, 0, 1, 1, 14'h0006, 8'h00, sgot);
    check("serial read msb", 8'h56, sgot);
    spi_xfer(1, 1, 0, 0, 14'h2a07, 8'h96, sgot);
    check_addr("serial write addr", 14'h2a07, reg_addr);
    spi_xfer(1, 0, 1, 1, 14'h2a07, 8'h00, sgot);
    check("serial readback", 8'h96, sgot);
    check_addr("serial read addr", 14'h2a07, reg_addr);
    spi_xfer(0, 1, 1, 0, 14'h0008, 8'h2d, sgot);
    spi_xfer(0, 1, 0, 1, 14'h0008, 8'h00, sgot);
    check("serial phase readback", 8'h2d, sgot);
  endtask
  initial begin
    cyc(12);
    resetn = 1;
    cyc(6);
    t_parallel;
    t_serial;
    finish_test;
  end
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
